// ---- vcp_pkg.sv ----
// Constants, field layouts and carrier types for the virtual command port
package vcp_pkg;

  // Register byte addresses on the local register port
  typedef logic [11:0] addr_t;
  typedef logic [63:0] data_t;
  localparam addr_t ADDR_COMMAND_SUBMIT = 12'h0e00;
  localparam addr_t ADDR_EXTRA_OPERAND = 12'h0e08;
  localparam addr_t ADDR_COMMAND_RESPONSE = 12'h0e10;
  localparam addr_t ADDR_PORT_CONFIG = 12'h0e20;
  localparam addr_t ADDR_EVENT_STATUS = 12'h0e40;
  localparam addr_t ADDR_EVENT_MASK = 12'h0e48;

  // Command codes
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_ALLOC_ID = 8'h01;
  localparam logic [7:0] CMD_FREE_ID = 8'h02;

  // Completion status codes
  localparam logic [6:0] SC_SUCCESS = 7'h00;
  localparam logic [6:0] SC_UNDEFINED = 7'h01;
  localparam logic [6:0] SC_NO_ID = 7'h10;
  localparam logic [6:0] SC_BAD_ID = 7'h10;

  // Identifier pool and execution timing
  localparam int POOL_SIZE = 16;
  localparam int ID_WIDTH = 20;
  localparam logic [2:0] EXEC_CYCLES = 3'h4;

  // Port configuration bits and their reset values
  localparam int CFG_IFACE_BIT = 0;
  localparam int CFG_ALLOC_BIT = 1;
  localparam int CFG_FREE_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h7;

  // Event bits: completion and error completion
  localparam int EV_DONE_BIT = 0;
  localparam int EV_ERROR_BIT = 1;
  localparam logic [1:0] EV_RESET = 2'h0;

  // Command submission layout: operand A 63:16, reserved 15:8, code 7:0
  typedef struct packed {
    logic [47:0] first_operand;
    logic [7:0] reserved;
    logic [7:0] code;
  } command_submit_s;

  // Response layout: result 63:16, reserved 15:8, status 7:1, in progress 0
  typedef struct packed {
    logic [47:0] command_result;
    logic [7:0] reserved;
    logic [6:0] completion_status_code;
    logic in_progress_flag;
  } command_response_s;

  localparam command_submit_s SUBMIT_RESET = 64'h0000_0000_0000_0000;
  localparam command_response_s RESPONSE_RESET = 64'h0000_0000_0000_0000;

endpackage : vcp_pkg

// ---- virtual_command_port.sv ----
// Virtual command port: command registers, identifier pool, response and events
// Notes on behaviour
// - Command register at E00h, operand, reserved, code
// - Code write clears response, sets in-progress flag
// - Writes to code and operands dropped while busy
// - Codes: null, allocate, free; others reserved
// - Second operand register, 64 bits, at E08h
// - Interface absent: registers read zero, ignore writes
// - Response at E10h: flag, status, result
// - Status zero success, one undefined command
// - Allocate returns identifier or 16; bad free 16
// - Unsupported command completes as undefined command
`timescale 1ns/1ps
module virtual_command_port
(
  input wire logic clk,
  input wire logic reset,
  input wire vcp_pkg::addr_t reg_addr,
  input wire vcp_pkg::data_t reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output vcp_pkg::data_t reg_rd_data,
  output logic irq
);
  import vcp_pkg::*;

  typedef enum {st_idle, st_run} run_state_e;

  command_submit_s command_submit;
  data_t extra_operand;
  command_response_s command_response;
  run_state_e run_state;
  logic [2:0] run_count;
  logic [2:0] port_config;
  logic [1:0] event_status;
  logic [1:0] event_mask;
  logic [POOL_SIZE-1:0] id_used;
  logic command_iface_supported;
  logic busy;
  logic wr_submit;
  logic wr_extra;
  logic start;
  logic finish;
  logic [6:0] next_status;
  logic [47:0] next_result;
  logic [POOL_SIZE-1:0] next_id_used;
  logic [1:0] events;
  logic ev_status_read;

  // Decode of the local register port
  assign command_iface_supported = port_config[CFG_IFACE_BIT];
  assign busy = command_response.in_progress_flag;
  assign wr_submit = reg_wr && reg_addr == ADDR_COMMAND_SUBMIT && command_iface_supported;
  assign wr_extra = reg_wr && reg_addr == ADDR_EXTRA_OPERAND && command_iface_supported;
  assign start = wr_submit && !busy;
  assign finish = run_state == st_run && run_count == 3'h0;
  assign ev_status_read = reg_rd && reg_addr == ADDR_EVENT_STATUS;

  // Command register; reserved byte is never stored, so it reads zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      command_submit <= SUBMIT_RESET;
    end
    else if (start)
    begin
      command_submit.first_operand <= reg_wr_data[63:16];
      command_submit.reserved <= 8'h00;
      command_submit.code <= reg_wr_data[7:0];
    end
  end

  // Second operand register, locked while a command runs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      extra_operand <= 64'h0000_0000_0000_0000;
    end
    else if (wr_extra && !busy)
    begin
      extra_operand <= reg_wr_data;
    end
  end

  // Software controls: port configuration and event mask
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      port_config <= CFG_RESET;
      event_mask <= EV_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_PORT_CONFIG)
      begin
        port_config <= reg_wr_data[2:0];
      end
      if (reg_addr == ADDR_EVENT_MASK)
      begin
        event_mask <= reg_wr_data[1:0];
      end
    end
  end

  // Command outcome, decided in the last cycle of execution
  always_comb
  begin
    next_status = SC_SUCCESS;
    next_result = 48'h0000_0000_0000;
    next_id_used = id_used;
    case (command_submit.code)
      CMD_NULL:
      begin
        next_status = SC_SUCCESS;
      end
      CMD_ALLOC_ID:
      begin
        if (!port_config[CFG_ALLOC_BIT])
        begin
          next_status = SC_UNDEFINED;
        end
        else
        begin
          next_status = SC_NO_ID;
          // Lowest free identifier wins; loop runs high to low so the last hit is lowest
          for (int i = POOL_SIZE - 1; i >= 0; i--)
          begin
            if (!id_used[i])
            begin
              next_status = SC_SUCCESS;
              next_result = {28'h000_0000, ID_WIDTH'(i)};
            end
          end
          if (next_status == SC_SUCCESS)
          begin
            next_id_used[next_result[3:0]] = 1'b1;
          end
        end
      end
      CMD_FREE_ID:
      begin
        if (!port_config[CFG_FREE_BIT])
        begin
          next_status = SC_UNDEFINED;
        end
        else if (command_submit.first_operand[19:4] == 16'h0000 && id_used[command_submit.first_operand[3:0]])
        begin
          next_status = SC_SUCCESS;
          next_id_used[command_submit.first_operand[3:0]] = 1'b0;
        end
        else
        begin
          next_status = SC_BAD_ID;
        end
      end
      default:
      begin
        next_status = SC_UNDEFINED;
      end
    endcase
  end

  // Execution sequencer and response register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_state <= st_idle;
      run_count <= 3'h0;
      command_response <= RESPONSE_RESET;
    end
    else
    begin
      case (run_state)
        st_idle:
        begin
          if (start)
          begin
            command_response <= RESPONSE_RESET;
            command_response.in_progress_flag <= 1'b1;
            run_count <= EXEC_CYCLES - 3'h1;
            run_state <= st_run;
          end
        end
        st_run:
        begin
          if (finish)
          begin
            command_response.in_progress_flag <= 1'b0;
            command_response.completion_status_code <= next_status;
            command_response.command_result <= next_result;
            run_state <= st_idle;
          end
          else
          begin
            run_count <= run_count - 3'h1;
          end
        end
        default:
        begin
          run_state <= st_idle;
        end
      endcase
    end
  end

  // Identifier pool; only changes when a command completes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      id_used <= '0;
    end
    else if (finish)
    begin
      id_used <= next_id_used;
    end
  end

  // Sticky events; a new event beats the clear made by reading the status
  assign events = {finish && next_status != SC_SUCCESS, finish};
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      event_status <= EV_RESET;
    end
    else
    begin
      event_status <= (ev_status_read ? 2'h0 : event_status) | events;
    end
  end

  // Interrupt is registered, so it trails the status bit by one cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(event_status & event_mask);
    end
  end

  // Read data, valid the cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rd_data <= 64'h0000_0000_0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_COMMAND_SUBMIT: reg_rd_data <= command_iface_supported ? command_submit : 64'h0;
        ADDR_EXTRA_OPERAND: reg_rd_data <= command_iface_supported ? extra_operand : 64'h0;
        ADDR_COMMAND_RESPONSE: reg_rd_data <= command_iface_supported ? command_response : 64'h0;
        ADDR_PORT_CONFIG: reg_rd_data <= {61'h0, port_config};
        ADDR_EVENT_STATUS: reg_rd_data <= {62'h0, event_status};
        ADDR_EVENT_MASK: reg_rd_data <= {62'h0, event_mask};
        default: reg_rd_data <= 64'h0000_0000_0000_0000;
      endcase
    end
    else
    begin
      reg_rd_data <= 64'h0000_0000_0000_0000;
    end
  end

  // Checks on the command port behaviour
  property p_cmd_reserved_zero;
    @(posedge clk) disable iff (reset)
    reg_rd && reg_addr == ADDR_COMMAND_SUBMIT |=> reg_rd_data[15:8] == 8'h00;
  endproperty
  a_cmd_reserved_zero: assert property (p_cmd_reserved_zero) else $error("reserved command bits read nonzero");

  property p_start_clears;
    @(posedge clk) disable iff (reset)
    start |=> command_response.in_progress_flag && command_response.completion_status_code == 7'h00
      && command_response.command_result == 48'h0;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("response not cleared at command start");

  property p_lock_submit;
    @(posedge clk) disable iff (reset)
    busy && reg_wr && reg_addr == ADDR_COMMAND_SUBMIT |=> $stable(command_submit);
  endproperty
  a_lock_submit: assert property (p_lock_submit) else $error("command written while busy");

  property p_lock_extra;
    @(posedge clk) disable iff (reset)
    busy && reg_wr && reg_addr == ADDR_EXTRA_OPERAND |=> $stable(extra_operand);
  endproperty
  a_lock_extra: assert property (p_lock_extra) else $error("second operand written while busy");

  property p_reserved_code;
    @(posedge clk) disable iff (reset)
    $fell(command_response.in_progress_flag) && command_submit.code > 8'h02
      |-> command_response.completion_status_code == 7'h01;
  endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("reserved code not undefined");

  property p_extra_store;
    @(posedge clk) disable iff (reset)
    wr_extra && !busy |=> extra_operand == $past(reg_wr_data) && !busy;
  endproperty
  a_extra_store: assert property (p_extra_store) else $error("second operand not stored");

  property p_absent_reads_zero;
    @(posedge clk) disable iff (reset)
    reg_rd && !command_iface_supported && (reg_addr == ADDR_COMMAND_SUBMIT || reg_addr == ADDR_EXTRA_OPERAND
      || reg_addr == ADDR_COMMAND_RESPONSE) |=> reg_rd_data == 64'h0;
  endproperty
  a_absent_reads_zero: assert property (p_absent_reads_zero) else $error("absent interface read nonzero");

  property p_flag_duration;
    @(posedge clk) disable iff (reset)
    $rose(command_response.in_progress_flag) |-> command_response.in_progress_flag [*4]
      ##1 !command_response.in_progress_flag;
  endproperty
  a_flag_duration: assert property (p_flag_duration) else $error("in-progress flag length wrong");

  property p_null_success;
    @(posedge clk) disable iff (reset)
    $fell(command_response.in_progress_flag) && command_submit.code == 8'h00
      |-> command_response.completion_status_code == 7'h00 && command_response.command_result == 48'h0;
  endproperty
  a_null_success: assert property (p_null_success) else $error("null command not successful");

  property p_alloc_result;
    @(posedge clk) disable iff (reset)
    $fell(command_response.in_progress_flag) && command_submit.code == 8'h01
      && command_response.completion_status_code == 7'h00
      |-> command_response.command_result < 48'h10 && id_used[command_response.command_result[3:0]];
  endproperty
  a_alloc_result: assert property (p_alloc_result) else $error("allocated identifier out of pool");

  property p_unsupported_free;
    @(posedge clk) disable iff (reset)
    finish && command_submit.code == 8'h02 && !port_config[2]
      |=> command_response.completion_status_code == 7'h01;
  endproperty
  a_unsupported_free: assert property (p_unsupported_free) else $error("unsupported free not undefined");

  c_alloc_ok: cover property (@(posedge clk) disable iff (reset)
    finish && command_submit.code == 8'h01 && next_status == 7'h00);
  c_pool_empty: cover property (@(posedge clk) disable iff (reset)
    finish && command_submit.code == 8'h01 && next_status == 7'h10);
  c_bad_free: cover property (@(posedge clk) disable iff (reset)
    finish && command_submit.code == 8'h02 && next_status == 7'h10);
  c_irq: cover property (@(posedge clk) disable iff (reset) $rose(irq));

endmodule : virtual_command_port

// ---- virtual_command_port_bench.sv ----
// Self-checking bench for the virtual command port
`timescale 1ns/1ps
module virtual_command_port_bench;
  import vcp_pkg::*;
  logic clk;
  logic reset;
  addr_t reg_addr;
  data_t reg_wr_data;
  logic reg_wr;
  logic reg_rd;
  data_t reg_rd_data;
  logic irq;
  int failures;
  int n_compared;
  int cycles = 0;
  int seed;
  int k;
  int c;
  data_t b;
  data_t d;
  data_t r;
  addr_t regs[7];
  data_t rst[7];

  virtual_command_port i_virtual_command_port
  (
    .clk(clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data),
    .irq(irq)
  );

  // 20 MHz clock
  always #25 clk = ~clk;

  task give_verdict;
    begin
      if (failures == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask : give_verdict

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  task check(input data_t got, input data_t exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask : check

  // Irq sampled mid-cycle so the edge update has landed
  task check_irq(input logic exp);
    begin
      @(negedge clk);
      n_compared++;
      if (irq !== exp)
      begin
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, irq, exp);
      end
      @(posedge clk);
    end
  endtask : check_irq

  // One idle cycle after each strobe keeps every signal to one assignment per step
  task wr(input addr_t a, input data_t v);
    begin
      reg_addr <= a;
      reg_wr_data <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask : wr

  task rd(input addr_t a, output data_t v);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rd_data;
      @(posedge clk);
    end
  endtask : rd

  function automatic data_t exp_rsp(input logic [6:0] sc, input logic [19:0] res);
    return {28'h000_0000, res, 8'h00, sc, 1'b0};
  endfunction : exp_rsp

  // Polls the busy flag, bounded so a stuck flag is reported
  task wait_done(output data_t v);
    int n;
    begin
      n = 0;
      rd(ADDR_COMMAND_RESPONSE, v);
      while (v[0] !== 1'b0 && n < 40)
      begin
        rd(ADDR_COMMAND_RESPONSE, v);
        n++;
      end
      if (v[0] !== 1'b0)
        failures++;
    end
  endtask : wait_done

  // Random operand noise around the identifier field
  task run_cmd(input logic [7:0] code, input logic [19:0] id, input logic [6:0] sc, input logic [19:0] res);
    begin
      d = {$random(seed), $random(seed)};
      d[35:16] = id;
      d[7:0] = code;
      wr(ADDR_COMMAND_SUBMIT, d);
      rd(ADDR_COMMAND_RESPONSE, r);
      check(r, 64'h0000_0000_0000_0001);
      wait_done(r);
      check(r, exp_rsp(sc, res));
    end
  endtask : run_cmd

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    reg_addr = 12'h000;
    reg_wr_data = 64'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    n_compared = 0;
    seed = 32'h445e_2dc2;
    regs = '{ADDR_COMMAND_SUBMIT, ADDR_EXTRA_OPERAND, ADDR_COMMAND_RESPONSE, ADDR_PORT_CONFIG,
      ADDR_EVENT_STATUS, ADDR_EVENT_MASK, 12'h0e18};
    rst = '{64'h0, 64'h0, 64'h0, 64'h7, 64'h0, 64'h0, 64'h0};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Reset values, read-only response and unmapped space
    wr(12'h0e18, '1);
    wr(ADDR_COMMAND_RESPONSE, '1);
    for (k = 0; k < 7; k++)
    begin
      rd(regs[k], r);
      check(r, rst[k]);
    end
    check_irq(1'b0);
    // Operand writes dropped while busy, including at the falling edge
    b = {$random(seed), $random(seed)};
    wr(ADDR_EXTRA_OPERAND, b);
    rd(ADDR_EXTRA_OPERAND, r);
    check(r, b);
    d = {$random(seed), $random(seed)};
    d[7:0] = CMD_NULL;
    wr(ADDR_COMMAND_SUBMIT, d);
    wr(ADDR_EXTRA_OPERAND, ~b);
    wr(ADDR_COMMAND_SUBMIT, ~d);
    wait_done(r);
    check(r, exp_rsp(SC_SUCCESS, 20'h0_0000));
    rd(ADDR_EXTRA_OPERAND, r);
    check(r, b);
    rd(ADDR_COMMAND_SUBMIT, r);
    check(r, d & 64'hffff_ffff_ffff_00ff);
    // Fill the pool, then refuse, free and reuse
    for (k = 0; k < 16; k++)
      run_cmd(CMD_ALLOC_ID, 20'h0_0000, SC_SUCCESS, k[19:0]);
    run_cmd(CMD_ALLOC_ID, 20'h0_0000, SC_NO_ID, 20'h0_0000);
    run_cmd(CMD_FREE_ID, 20'h0_0014, SC_BAD_ID, 20'h0_0000);
    run_cmd(CMD_FREE_ID, 20'h0_0005, SC_SUCCESS, 20'h0_0000);
    run_cmd(CMD_FREE_ID, 20'h0_0005, SC_BAD_ID, 20'h0_0000);
    run_cmd(CMD_ALLOC_ID, 20'h0_0000, SC_SUCCESS, 20'h0_0005);
    // Reserved codes, both ends of the range among random ones
    for (k = 0; k < 10; k++)
    begin
      c = (k == 0) ? 3 : (k == 1) ? 255 : 3 + ($unsigned($random(seed)) % 253);
      run_cmd(c[7:0], 20'h0_0000, SC_UNDEFINED, 20'h0_0000);
    end
    // Interface switched off: registers read zero, writes ignored
    wr(ADDR_PORT_CONFIG, 64'h6);
    for (k = 0; k < 3; k++)
    begin
      rd(regs[k], r);
      check(r, 64'h0);
    end
    wr(ADDR_EXTRA_OPERAND, ~b);
    wr(ADDR_COMMAND_SUBMIT, {56'h0, CMD_NULL});
    wr(ADDR_PORT_CONFIG, 64'h5);
    rd(ADDR_EXTRA_OPERAND, r);
    check(r, b);
    rd(ADDR_COMMAND_RESPONSE, r);
    check(r, exp_rsp(SC_UNDEFINED, 20'h0_0000));
    // Commands reported unsupported complete as undefined
    run_cmd(CMD_ALLOC_ID, 20'h0_0000, SC_UNDEFINED, 20'h0_0000);
    wr(ADDR_PORT_CONFIG, 64'h3);
    run_cmd(CMD_FREE_ID, 20'h0_0003, SC_UNDEFINED, 20'h0_0000);
    wr(ADDR_PORT_CONFIG, 64'h7);
    run_cmd(CMD_FREE_ID, 20'h0_0003, SC_SUCCESS, 20'h0_0000);
    // Sticky events, read clear and masking
    rd(ADDR_EVENT_STATUS, r);
    check(r, 64'h3);
    rd(ADDR_EVENT_STATUS, r);
    check(r, 64'h0);
    wr(ADDR_EVENT_MASK, 64'h3);
    run_cmd(CMD_NULL, 20'h0_0000, SC_SUCCESS, 20'h0_0000);
    repeat (2) @(posedge clk);
    check_irq(1'b1);
    rd(ADDR_EVENT_STATUS, r);
    check(r, 64'h1);
    check_irq(1'b0);
    wr(ADDR_EVENT_MASK, 64'h2);
    run_cmd(CMD_NULL, 20'h0_0000, SC_SUCCESS, 20'h0_0000);
    repeat (2) @(posedge clk);
    check_irq(1'b0);
    run_cmd(8'h09, 20'h0_0000, SC_UNDEFINED, 20'h0_0000);
    repeat (2) @(posedge clk);
    check_irq(1'b1);
    rd(ADDR_EVENT_STATUS, r);
    check(r, 64'h3);
    check_irq(1'b0);
    give_verdict();
  end
endmodule : virtual_command_port_bench
